// [flash_ctl_pkg.sv]
package flash_ctl_pkg;

	// ------------------------------------------------------------
	// command codes on the command interface
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
	localparam logic [7:0] CMD_READ_ID     = 8'h90;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_CONFIRM     = 8'hd0;
	localparam logic [7:0] CMD_PROG_SETUP  = 8'h40;
	localparam logic [7:0] CMD_PROG_ALT    = 8'h10;
	localparam logic [7:0] CMD_SUSPEND     = 8'hb0;

	// ------------------------------------------------------------
	// status register bit positions
	// ------------------------------------------------------------
	localparam int SR_READY   = 7;
	localparam int SR_ESUSP   = 6;
	localparam int SR_ERASE   = 5;
	localparam int SR_PROG    = 4;
	localparam int SR_PSUSP   = 2;
	localparam logic [7:0] SR_RESET = 8'h80;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ      = 50;
	localparam int PROG_TIME_US = 10;
	localparam int ERASE_TIME_US = 1000;
	localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
	localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;

	// read modes and engine states
	typedef enum logic [1:0] {MODE_ARRAY, MODE_ID, MODE_STATUS} read_mode_t;
	typedef enum logic [2:0] {ENG_IDLE, ENG_PSET, ENG_ESET, ENG_BUSY, ENG_SUSP} eng_state_t;

endpackage : flash_ctl_pkg

// [flash_mode_ctl.sv]
// How it works
// - in mux-address mode ready_busy_n copies status bit 7
// - reads of array, id and status ignore program-supply level
// - program or erase refused while program_supply_lockout is set
// - power-up or reset exit puts device in read-array mode
// - commands accepted at any address; block commands use given block
// - host outputs high impedance whenever no cycle selects device
// - either reset pin low resets, deselects, tri-states, stops activity
// - leaving reset sets every block write lock to locked; every read lock clears
// - reset during program or erase aborts it
// - top_block_protect_n low rejects program/erase in top block
// - write_protect_n low rejects program/erase in all other blocks
// - protect pins sampled when program or erase starts
// - pin changes during suspend take effect after operation finishes
// - active protect pin blocks writes whatever lock registers say
// - read-lock bit may still be set while protect pin active
// - top block is 7 in 4-Mbit, 15 in 8-Mbit variant
// - status bit 7 is 1 ready, 0 busy
module flash_mode_ctl #(
	parameter int BLOCKS       = 16,
	parameter int PROG_CYCLES  = flash_ctl_pkg::PROG_CYCLES,
	parameter int ERASE_CYCLES = flash_ctl_pkg::ERASE_CYCLES
) (
	// clock and resets
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              hard_reset_n,
	input  wire logic              cpu_soft_reset_n,
	// host cycle
	input  wire logic              cycle_select,
	input  wire logic              cycle_write,
	input  wire logic              cycle_strobe,
	input  wire logic [3:0]        block_addr,
	input  wire logic [7:0]        wr_data,
	input  wire logic              mux_mode,
	// protection and supply
	input  wire logic              top_block_protect_n,
	input  wire logic              write_protect_n,
	input  wire logic              program_supply_lockout,
	input  wire logic              core_supply_lockout,
	// lock register access
	input  wire logic              lock_wr,
	input  wire logic [3:0]        lock_blk,
	input  wire logic [1:0]        lock_val,
	// outputs
	output logic                   host_out_en,
	output logic [1:0]             read_mode,
	output logic [7:0]             status,
	output logic                   ready_busy_n,
	output logic [BLOCKS-1:0]      write_lock,
	output logic [BLOCKS-1:0]      read_lock,
	output logic                   array_write,
	output logic                   array_erase,
	output logic [3:0]             op_block
);

	// ------------------------------------------------------------
	// synchronise pins
	// ------------------------------------------------------------
	logic [1:0] rst_s1_q, rst_s2_q, prot_s1_q, prot_s2_q, sup_s1_q, sup_s2_q;
	logic       sel_s1_q, sel_s2_q, stb_s1_q, stb_s2_q, stb_d2_q;
	logic [13:0] bus_s1_q, bus_s2_q; // {mux_mode, cycle_write, block_addr, wr_data}
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rst_s1_q  <= 2'h0;
			rst_s2_q  <= 2'h0;
			prot_s1_q <= 2'h0;
			prot_s2_q <= 2'h0;
			sup_s1_q  <= 2'h3;
			sup_s2_q  <= 2'h3;
			sel_s1_q  <= 1'b0;
			sel_s2_q  <= 1'b0;
			stb_s1_q  <= 1'b0;
			stb_s2_q  <= 1'b0;
			stb_d2_q  <= 1'b0;
			bus_s1_q  <= 14'h0;
			bus_s2_q  <= 14'h0;
		end
		else
		begin
			rst_s1_q  <= {hard_reset_n, cpu_soft_reset_n};
			rst_s2_q  <= rst_s1_q;
			prot_s1_q <= {top_block_protect_n, write_protect_n};
			prot_s2_q <= prot_s1_q;
			sup_s1_q  <= {program_supply_lockout, core_supply_lockout};
			sup_s2_q  <= sup_s1_q;
			sel_s1_q  <= cycle_select;
			sel_s2_q  <= sel_s1_q;
			stb_s1_q  <= cycle_strobe;
			stb_s2_q  <= stb_s1_q;
			stb_d2_q  <= stb_s2_q;
			bus_s1_q  <= {mux_mode, cycle_write, block_addr, wr_data};
			bus_s2_q  <= bus_s1_q;
		end
	end

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	// either reset pin low resets engine state, status, read mode, locks and host output enable
	wire pin_reset = ~&rst_s2_q;
	wire top_pin_on = ~prot_s2_q[1];
	wire wp_pin_on  = ~prot_s2_q[0];
	wire lockout    = |sup_s2_q;
	// host pins travel one synchroniser; they settle well before the strobe edge
	wire mux_on     = bus_s2_q[13];
	wire wr_cyc     = bus_s2_q[12];
	wire [3:0] blk_in = bus_s2_q[11:8];
	// address and data are only sampled when the strobe edge is seen
	wire wr_evt     = stb_s2_q & ~stb_d2_q & wr_cyc & sel_s2_q;
	wire [3:0] top_blk = 4'(BLOCKS - 1);
	wire is_top     = (blk_in == top_blk);
	wire [7:0] cmd  = bus_s2_q[7:0];
	wire is_prog    = (cmd == flash_ctl_pkg::CMD_PROG_SETUP) | (cmd == flash_ctl_pkg::CMD_PROG_ALT);

	flash_ctl_pkg::eng_state_t st_q;
	logic       top_prot_q, wp_prot_q, is_erase_q;
	logic [31:0] cnt_q;
	logic [3:0] blk_q;

	// protection latched at start; unaffected by suspend changes
	wire pin_block = (blk_q == top_blk) ? top_prot_q : wp_prot_q;
	wire samp_pin  = is_top ? top_pin_on : wp_pin_on;
	wire reg_block = write_lock[blk_in];
	wire refuse    = lockout | samp_pin | reg_block;
	wire start_ok  = wr_evt & ~refuse;
	wire done      = (st_q == flash_ctl_pkg::ENG_BUSY) & (cnt_q == 32'h0);

	// ------------------------------------------------------------
	// write engine
	// ------------------------------------------------------------
	// the counter is a 32-bit down count; long erase times need it wide
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_q       <= flash_ctl_pkg::ENG_IDLE;
			cnt_q      <= 32'h0;
			blk_q      <= 4'h0;
			is_erase_q <= 1'b0;
			top_prot_q <= 1'b1;
			wp_prot_q  <= 1'b1;
			status     <= flash_ctl_pkg::SR_RESET;
			read_mode  <= 2'h0;
		end
		else if (pin_reset)
		begin
			st_q      <= flash_ctl_pkg::ENG_IDLE;
			status    <= flash_ctl_pkg::SR_RESET;
			read_mode <= 2'(flash_ctl_pkg::MODE_ARRAY);
		end
		else
		begin
			unique case (st_q)
				flash_ctl_pkg::ENG_IDLE:
				begin
					if (wr_evt)
					begin
						read_mode <= 2'(flash_ctl_pkg::MODE_ARRAY);
						if (cmd == flash_ctl_pkg::CMD_READ_ID)
							read_mode <= 2'(flash_ctl_pkg::MODE_ID);
						if (cmd == flash_ctl_pkg::CMD_READ_STATUS)
							read_mode <= 2'(flash_ctl_pkg::MODE_STATUS);
						if (cmd == flash_ctl_pkg::CMD_CLEAR_STAT)
							status <= flash_ctl_pkg::SR_RESET;
						if (is_prog)
							st_q <= flash_ctl_pkg::ENG_PSET;
						if (cmd == flash_ctl_pkg::CMD_ERASE_SETUP)
							st_q <= flash_ctl_pkg::ENG_ESET;
					end
				end
				flash_ctl_pkg::ENG_PSET, flash_ctl_pkg::ENG_ESET:
				begin
					if (wr_evt)
					begin
						is_erase_q <= (st_q == flash_ctl_pkg::ENG_ESET);
						read_mode  <= 2'(flash_ctl_pkg::MODE_STATUS);
						blk_q      <= blk_in;
						top_prot_q <= top_pin_on;
						wp_prot_q  <= wp_pin_on;
						if (start_ok)
						begin
							st_q   <= flash_ctl_pkg::ENG_BUSY;
							status[flash_ctl_pkg::SR_READY] <= 1'b0;
							cnt_q  <= (st_q == flash_ctl_pkg::ENG_ESET) ?
								32'(ERASE_CYCLES) : 32'(PROG_CYCLES);
						end
						else
						begin
							st_q <= flash_ctl_pkg::ENG_IDLE;
							if (st_q == flash_ctl_pkg::ENG_ESET)
								status[flash_ctl_pkg::SR_ERASE] <= 1'b1;
							else
								status[flash_ctl_pkg::SR_PROG] <= 1'b1;
						end
					end
				end
				flash_ctl_pkg::ENG_BUSY:
				begin
					if (done)
					begin
						st_q <= flash_ctl_pkg::ENG_IDLE;
						status[flash_ctl_pkg::SR_READY] <= 1'b1;
					end
					else if (wr_evt & (cmd == flash_ctl_pkg::CMD_SUSPEND))
					begin
						st_q <= flash_ctl_pkg::ENG_SUSP;
						status[flash_ctl_pkg::SR_READY] <= 1'b1;
						if (is_erase_q)
							status[flash_ctl_pkg::SR_ESUSP] <= 1'b1;
						else
							status[flash_ctl_pkg::SR_PSUSP] <= 1'b1;
					end
					else
						cnt_q <= cnt_q - 32'h1;
				end
				flash_ctl_pkg::ENG_SUSP:
				begin
					// resume keeps the protection latched at start
					if (wr_evt & (cmd == flash_ctl_pkg::CMD_CONFIRM))
					begin
						st_q <= flash_ctl_pkg::ENG_BUSY;
						status[flash_ctl_pkg::SR_READY] <= 1'b0;
						status[flash_ctl_pkg::SR_ESUSP] <= 1'b0;
						status[flash_ctl_pkg::SR_PSUSP] <= 1'b0;
					end
					else if (wr_evt)
						read_mode <= 2'(flash_ctl_pkg::MODE_ARRAY);
				end
				default:
					st_q <= flash_ctl_pkg::ENG_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// block locks: write locks set and read locks cleared on reset exit, read-lock always settable
	// ------------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < BLOCKS; b++)
		begin : g_lock
			always_ff @(posedge clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					write_lock[b] <= 1'b1;
					read_lock[b]  <= 1'b0;
				end
				else if (pin_reset)
				begin
					write_lock[b] <= 1'b1;
					read_lock[b]  <= 1'b0;
				end
				else if (lock_wr & (lock_blk == 4'(b)))
				begin
					write_lock[b] <= lock_val[0];
					read_lock[b]  <= lock_val[1];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// pin outputs and array strobes
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			host_out_en  <= 1'b0;
			ready_busy_n <= 1'b1;
			array_write  <= 1'b0;
			array_erase  <= 1'b0;
			op_block     <= 4'h0;
		end
		else
		begin
			host_out_en  <= sel_s2_q & ~wr_cyc & ~pin_reset;
			ready_busy_n <= mux_on ? status[flash_ctl_pkg::SR_READY] : 1'b1;
			// pin_block guards against a latched protection slipping through
			array_write  <= done & ~is_erase_q & ~pin_block & ~pin_reset;
			array_erase  <= done & is_erase_q & ~pin_block & ~pin_reset;
			op_block     <= blk_q;
		end
	end

endmodule : flash_mode_ctl

// [flash_mode_ctl_props.sv]
module flash_mode_ctl_props #(
	parameter int BLOCKS = 16
) (
	// clock and resets
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic              hard_reset_n,
	input wire logic              cpu_soft_reset_n,
	// host and pins
	input wire logic              cycle_select,
	input wire logic              mux_mode,
	input wire logic              top_block_protect_n,
	input wire logic              write_protect_n,
	input wire logic              program_supply_lockout,
	// design outputs
	input wire logic              host_out_en,
	input wire logic [1:0]        read_mode,
	input wire logic [7:0]        status,
	input wire logic              ready_busy_n,
	input wire logic [BLOCKS-1:0] write_lock,
	input wire logic              array_write,
	input wire logic              array_erase,
	input wire logic [3:0]        op_block
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// helpers; pin resets pass a synchroniser, hence the four- and five-cycle holds below
	wire pin_rst = !hard_reset_n || !cpu_soft_reset_n;
	wire op_end  = array_write || array_erase;
	wire top_op  = op_block == 4'(BLOCKS - 1);
	// pins as they stood when a fresh job went busy; a suspended job keeps them
	logic tbp_start, wp_start;
	always_ff @(posedge clk)
	begin
		if (status[7] && !status[6] && !status[2])
		begin
			tbp_start <= top_block_protect_n;
			wp_start  <= write_protect_n;
		end
	end
	// mode is required now and three cycles back so the pin has caught up
	rdy_copy_a: assert property (mux_mode && $past(mux_mode, 3) && $stable(status)
		|-> ready_busy_n == status[7]) else $error("ready pin not a copy of status");
	rdy_idle_a: assert property (!mux_mode && !$past(mux_mode, 3) |-> ready_busy_n)
		else $error("ready pin low outside mux mode");
	hiz_idle_a: assert property (!cycle_select [*5] |-> !host_out_en)
		else $error("host outputs driven while unselected");
	rst_state_a: assert property (pin_rst [*5] |-> status == 8'h80
		&& read_mode == 2'h0 && !host_out_en) else $error("pin reset state wrong");
	rst_lock_a: assert property (pin_rst [*5] |-> &write_lock)
		else $error("blocks not relocked by reset");
	rst_abort_a: assert property (pin_rst [*4] |=> !op_end)
		else $error("operation finished under reset");
	busy_end_a: assert property (op_end |-> !$past(status[7], 2))
		else $error("operation ended without busy status");
	top_prot_a: assert property (op_end && top_op |-> tbp_start)
		else $error("top block altered while protected");
	wp_prot_a: assert property (op_end && !top_op |-> wp_start)
		else $error("block altered while write protected");
	supply_lock_a: assert property (op_end |-> !program_supply_lockout && !write_lock[op_block])
		else $error("block altered under lockout or lock");
	cover property (array_write);
	cover property (status[6] ##1 !status[6]);
	cover property (array_erase);
	cover property (pin_rst ##1 !pin_rst);
endmodule : flash_mode_ctl_props

bind flash_mode_ctl flash_mode_ctl_props #(.BLOCKS(BLOCKS)) u_props (.*);

// [host_model.sv]
module host_model (
	// clock
	input wire logic clk,
	// host cycle
	output logic       cycle_select,
	output logic       cycle_write,
	output logic       cycle_strobe,
	output logic [3:0] block_addr,
	output logic [7:0] wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	int slow = 0; // extra strobe cycles for a sluggish host
	initial {cycle_select, cycle_write, cycle_strobe, block_addr, wr_data} = '0;
	// write cycle; block commands carry an address inside the target block
	task automatic wr(input logic [3:0] blk, input logic [7:0] d);
		@(posedge clk);
		cycle_select <= 1'b1;
		cycle_write  <= 1'b1;
		block_addr   <= blk;
		wr_data      <= d;
		@(posedge clk);
		cycle_strobe <= 1'b1;
		repeat (3 + slow) @(posedge clk);
		cycle_strobe <= 1'b0;
		repeat (2) @(posedge clk);
		cycle_select <= 1'b0;
		wr_data      <= ~d; // released lines never keep the last byte
		block_addr   <= ~blk;
	endtask : wr
	// read cycle of n clocks
	task automatic rd(input int n);
		@(posedge clk);
		cycle_select <= 1'b1;
		cycle_write  <= 1'b0;
		repeat (n) @(posedge clk);
		cycle_select <= 1'b0;
	endtask : rd
endmodule : host_model

// [tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BLK = 16;
	logic clk = 1'b0, sys_rst = 1'b1, hard_reset_n = 1'b0, cpu_soft_reset_n = 1'b0;
	logic mux_mode = 1'b1, top_block_protect_n = 1'b1, write_protect_n = 1'b1;
	logic program_supply_lockout = 1'b0, core_supply_lockout = 1'b0, lock_wr = 1'b0;
	logic [3:0] lock_blk = 4'h0, block_addr, op_block;
	logic [1:0] lock_val = 2'h0, read_mode;
	logic [7:0] wr_data, status;
	logic cycle_select, cycle_write, cycle_strobe, host_out_en, ready_busy_n;
	logic array_write, array_erase;
	logic [BLK-1:0] write_lock, read_lock;
	int failures = 0, comparisons = 0, cyc = 0, ends = 0;
	flash_mode_ctl #(.BLOCKS(BLK), .PROG_CYCLES(8), .ERASE_CYCLES(20)) u_dut (.*);
	host_model hm (.*);
	initial forever #10 clk = ~clk;
	// pulse count and hang guard
	always @(posedge clk)
	begin
		ends <= ends + array_write + array_erase;
		cyc <= cyc + 1;
		if (cyc == 10000)
		begin
			failures++;
			give_verdict();
		end
	end
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic give_verdict();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	task automatic lock_set(input logic [3:0] b, input logic [1:0] v);
		@(posedge clk);
		lock_wr  <= 1'b1;
		lock_blk <= b;
		lock_val <= v;
		@(posedge clk);
		lock_wr  <= 1'b0;
		repeat (3) @(negedge clk);
	endtask : lock_set
	// a refused job leaves ready status plus its own error bit
	function automatic logic [7:0] exp_sr(logic [3:0] b, logic er, logic wl);
		logic deny;
		deny = program_supply_lockout || wl || (b == BLK - 1 ? !top_block_protect_n : !write_protect_n);
		return deny ? (er ? 8'ha0 : 8'h90) : 8'h80;
	endfunction : exp_sr
	task automatic run_op(input logic [3:0] b, input logic er, input logic wl);
		logic [7:0] e;
		int n;
		e = exp_sr(b, er, wl);
		n = ends;
		hm.wr(b, er ? 8'h20 : ($urandom_range(1) ? 8'h40 : 8'h10));
		hm.wr(b, er ? 8'hd0 : 8'($urandom));
		@(negedge clk);
		if (e == 8'h80)
			chk("busy", {status[7], ready_busy_n}, {1'b0, !mux_mode});
		for (int i = 0; i < 40 && status[7] !== 1'b1; i++) @(negedge clk);
		repeat (2) @(negedge clk);
		chk("status", status, e);
		chk("block", 16'(op_block), 16'(b));
		chk("pulses", 16'(ends - n), 16'(e == 8'h80));
		hm.wr(b, 8'h50);
	endtask : run_op
	// reset, read modes, random jobs, a suspended erase, then aborts by each reset pin
	initial
	begin
		logic [7:0] cmd [4] = '{8'h90, 8'h70, 8'hff, 8'h70};
		logic [1:0] mode [4] = '{2'h1, 2'h2, 2'h0, 2'h2};
		logic [3:0] b;
		logic er, wl, rl;
		int n;
		void'($urandom(32'h56c81bcc));
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		{hard_reset_n, cpu_soft_reset_n} <= 2'b11;
		repeat (5) @(negedge clk);
		chk("reset", {status, read_mode, host_out_en}, {8'h80, 2'h0, 1'b0});
		chk("wlock", write_lock, 16'hffff);
		chk("rlock", read_lock, 16'h0000);
		foreach (cmd[i])
		begin
			@(posedge clk);
			program_supply_lockout <= 1'(i);
			hm.wr(4'($urandom), cmd[i]);
			fork
				hm.rd(6);
				#110 chk("read", {read_mode, host_out_en}, {mode[i], 1'b1});
			join
			repeat (6) @(negedge clk);
			chk("idle", host_out_en, 1'b0);
		end
		$display("test reads done");
		for (int k = 0; k < 40; k++)
		begin
			b = k < 4 ? 4'(BLK - 1) : 4'($urandom);
			er = 1'($urandom);
			wl = k > 1 && $urandom_range(3) == 0;
			rl = 1'($urandom);
			@(posedge clk);
			mux_mode <= 1'($urandom);
			top_block_protect_n <= k > 1 && 1'($urandom);
			write_protect_n <= 1'($urandom);
			program_supply_lockout <= $urandom_range(4) == 0;
			hm.slow = $urandom_range(1);
			lock_set(b, {rl, wl});
			chk("locks", {read_lock[b], write_lock[b]}, {rl, wl});
			run_op(b, er, wl);
		end
		$display("test random jobs done");
		// erase suspended mid-way; a protect pin driven low meanwhile must not stop the resume
		hm.slow = 0;
		{top_block_protect_n, write_protect_n, program_supply_lockout} <= 3'b110;
		lock_set(4'h2, 2'h0);
		n = ends;
		hm.wr(4'h2, 8'h20);
		hm.wr(4'h2, 8'hd0);
		hm.wr(4'h2, 8'hb0);
		write_protect_n <= 1'b0;
		@(negedge clk);
		chk("suspend", {status, 4'(ends - n)}, {8'hc0, 4'h0});
		hm.wr(4'h2, 8'hd0);
		for (int i = 0; i < 40 && status[7] !== 1'b1; i++) @(negedge clk);
		repeat (2) @(negedge clk);
		chk("resume", {status, 4'(ends - n)}, {8'h80, 4'h1});
		$display("test suspend done");
		for (int r = 0; r < 2; r++)
		begin
			@(posedge clk);
			{top_block_protect_n, write_protect_n, program_supply_lockout} <= 3'b110;
			lock_set(4'h3, 2'h0);
			hm.wr(4'h3, 8'h20);
			hm.wr(4'h3, 8'hd0);
			n = ends;
			{hard_reset_n, cpu_soft_reset_n} <= r ? 2'b10 : 2'b01;
			repeat (30) @(posedge clk);
			{hard_reset_n, cpu_soft_reset_n} <= 2'b11;
			repeat (5) @(negedge clk);
			chk("abort", {4'(ends - n), status, read_mode}, {4'h0, 8'h80, 2'h0});
			chk("relock", write_lock, 16'hffff);
		end
		$display("test abort done");
		give_verdict();
	end
endmodule : tb
